// ===== frtr_pkg.sv
// shared constants and carrier types for the test and ram-init block
`default_nettype none
package frtr_pkg;
	localparam int RAM_INIT_CYCLES = 2049;
	localparam int SAMPLE_DIV = 8;
	localparam int VOTE_TAPS = 3;
	localparam int IDLE_BITS = 11;
	localparam logic [3:0] CMD_RAM_CLEAR_COMMAND = 4'hC;
	localparam logic [1:0] TMC_NORMAL = 2'h0;
	localparam logic [1:0] TMC_RAM_TEST = 2'h1;
	localparam logic [1:0] TMC_IO_TEST = 2'h2;
	localparam logic [1:0] CER_NONE = 2'h0;
	localparam logic [1:0] CER_CRC = 2'h1;
	localparam logic [1:0] CER_FES = 2'h2;
	localparam logic [1:0] CER_OTHER = 2'h3;
	localparam logic [31:0] RAM_CLEAR_VALUE = 32'h00000000;

	typedef struct packed {
		logic [3:0] cmd;
		logic cmd_strobe;
		logic [1:0] test_mux_control;
		logic async_tx_mode;
		logic loop_back;
		logic io_txd;
		logic io_txen;
	} frtr_ctrl_t;

	typedef struct packed {
		logic crc_err;
		logic fes_err;
		logic other_err;
		logic frame_end;
	} frtr_rx_err_t;
endpackage : frtr_pkg
`default_nettype wire

// ===== frtr_rx_filter.sv
// receive line synchroniser, sample enable and majority vote filter
`timescale 1ns/1ns
`default_nettype none
module frtr_rx_filter #(
	parameter int DIV = frtr_pkg::SAMPLE_DIV
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// line
	input wire logic rx_line_in,
	// filtered result
	output logic rx_voted_out,
	output logic sample_en_out
);
	typedef struct packed {
		logic [2:0] sync;
		logic [7:0] div;
		logic [2:0] taps;
		logic voted;
		logic en;
	} frtr_rxf_state_t;

	frtr_rxf_state_t s_q;
	frtr_rxf_state_t s_d;
	logic settled;

	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], rx_line_in};
		// second and third stages must agree before a change counts
		settled = (s_q.sync[1] == s_q.sync[2]) ? s_q.sync[2] : s_q.voted;
		s_d.en = 1'b0;
		if (s_q.div == 8'(DIV - 1)) begin
			s_d.div = 8'h00;
			s_d.en = 1'b1;
			s_d.taps = {s_q.taps[1:0], settled};
		end else begin
			s_d.div = s_q.div + 8'h01;
		end
		// two of three vote: a delay of two sample periods is absorbed
		if (s_q.en) begin
			s_d.voted = (s_q.taps[0] & s_q.taps[1]) | (s_q.taps[1] & s_q.taps[2])
				| (s_q.taps[0] & s_q.taps[2]);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_q <= '{sync: 3'h7, div: 8'h00, taps: 3'h7, voted: 1'b1, en: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rx_voted_out = s_q.voted;
	assign sample_en_out = s_q.en;
endmodule : frtr_rx_filter
`default_nettype wire

// ===== frtr_core.sv
// test mux, bus activity, ram clear, coding errors and interrupt flags
// Function
// - receive tolerates two sample periods delay
// - loop-back receives every transmitted message outside io test
// - activity bit reads one unless bus idle
// - ram initialisation lasts 2049 clock cycles
// - clear-active flag falls exactly at sequence end
// - decoding error beats crc in report
// - unwritten location read raises ecc error
// - clear command writes every ram location
// - interrupt line flag set beats clear
// - service request only on rising flag
`timescale 1ns/1ns
`default_nettype none
module frtr_core #(
	parameter int RAM_WORDS = 2048,
	parameter int ADDR_W = 11,
	parameter int INIT_CYCLES = frtr_pkg::RAM_INIT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// control from host
	input wire frtr_pkg::frtr_ctrl_t ctrl_in,
	input wire logic [1:0] int_clear_in,
	// ram access from host
	input wire logic ram_wr_in,
	input wire logic ram_rd_in,
	input wire logic [ADDR_W-1:0] ram_addr_in,
	input wire logic [31:0] ram_wdata_in,
	output logic [31:0] ram_rdata_out,
	output logic ram_ecc_err_out,
	// protocol engine side
	input wire logic [1:0] int_event_in,
	input wire frtr_pkg::frtr_rx_err_t rx_err_in,
	input wire logic pe_txd_in,
	input wire logic pe_txen_in,
	input wire logic rx_line_in,
	output logic pe_rxd_out,
	output logic protocol_enable_out,
	// transceiver pins
	output logic transmit_data_line_out,
	output logic transmit_enable_line_out,
	// status
	output logic ram_clear_active_out,
	output logic bus_activity_observed_out,
	output logic [1:0] coding_error_report_out,
	output logic [1:0] int_flags_out,
	output logic [1:0] int_request_out
);
	typedef struct packed {
		logic clearing;
		logic [11:0] init_cnt;
		logic [ADDR_W-1:0] clr_addr;
		logic [1:0] iflag;
		logic [1:0] ireq;
		logic [1:0] cer;
		logic [3:0] idle_cnt;
		logic active;
		logic [31:0] rdata;
		logic ecc;
	} frtr_state_t;

	frtr_state_t s_q;
	frtr_state_t s_d;
	logic [31:0] mem [RAM_WORDS];
	logic [RAM_WORDS-1:0] written_q;
	logic rx_voted;
	logic sample_en;
	logic start_clear;
	logic io_test;

	frtr_rx_filter #(.DIV(frtr_pkg::SAMPLE_DIV)) u_rx_filter (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.rx_line_in(rx_line_in),
		.rx_voted_out(rx_voted),
		.sample_en_out(sample_en)
	);

	assign start_clear = ctrl_in.cmd_strobe
		&& ctrl_in.cmd == frtr_pkg::CMD_RAM_CLEAR_COMMAND && !s_q.clearing;
	assign io_test = ctrl_in.test_mux_control == frtr_pkg::TMC_IO_TEST;

	always_comb begin
		s_d = s_q;
		// ram initialisation counter
		if (start_clear) begin
			s_d.clearing = 1'b1;
			s_d.init_cnt = 12'h000;
			s_d.clr_addr = '0;
		end else if (s_q.clearing) begin
			if (s_q.init_cnt == 12'(INIT_CYCLES - 1)) begin
				s_d.clearing = 1'b0;
			end
			s_d.init_cnt = s_q.init_cnt + 12'h001;
			if (s_q.clr_addr != ADDR_W'(RAM_WORDS - 1)) begin
				s_d.clr_addr = s_q.clr_addr + 1'b1;
			end
		end
		// set wins over clear; request on zero-to-one only
		s_d.iflag = (s_q.iflag & ~int_clear_in) | int_event_in;
		s_d.ireq = s_d.iflag & ~s_q.iflag;
		// decoding error takes precedence over crc error
		if (rx_err_in.frame_end) begin
			if (rx_err_in.fes_err) begin
				s_d.cer = frtr_pkg::CER_FES;
			end else if (rx_err_in.crc_err) begin
				s_d.cer = frtr_pkg::CER_CRC;
			end else if (rx_err_in.other_err) begin
				s_d.cer = frtr_pkg::CER_OTHER;
			end else begin
				s_d.cer = frtr_pkg::CER_NONE;
			end
		end
		// idle is a run of high samples; low restarts activity
		if (sample_en) begin
			if (!rx_voted) begin
				s_d.active = 1'b1;
				s_d.idle_cnt = 4'h0;
			end else if (s_q.idle_cnt == 4'(frtr_pkg::IDLE_BITS - 1)) begin
				s_d.active = 1'b0;
			end else begin
				s_d.idle_cnt = s_q.idle_cnt + 4'h1;
			end
		end
		s_d.ecc = 1'b0;
		if (ram_rd_in && !s_q.clearing) begin
			s_d.rdata = mem[ram_addr_in];
			// read of unwritten word flags ecc error
			s_d.ecc = !written_q[ram_addr_in];
		end
	end

	// defined value into every location during clear
	always_ff @(posedge sys_clk_in) begin
		if (s_q.clearing) begin
			mem[s_q.clr_addr] <= frtr_pkg::RAM_CLEAR_VALUE;
		end else if (ram_wr_in) begin
			mem[ram_addr_in] <= ram_wdata_in;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < RAM_WORDS; gi++) begin : g_written
			always_ff @(posedge sys_clk_in) begin
				if (reset_in) begin
					written_q[gi] <= 1'b0;
				end else if (s_q.clearing && s_q.clr_addr == ADDR_W'(gi)) begin
					written_q[gi] <= 1'b1;
				end else if (ram_wr_in && !s_q.clearing
					&& ram_addr_in == ADDR_W'(gi)) begin
					written_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// hardware reset starts a ram clear too
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_q <= '0;
			s_q.clearing <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// io test drives the pins from host bits; loop-back feeds tx to rx outside io test
	always_comb begin
		if (io_test) begin
			transmit_data_line_out = ctrl_in.io_txd;
			transmit_enable_line_out = ctrl_in.io_txen;
		end else begin
			transmit_data_line_out = pe_txd_in;
			transmit_enable_line_out = pe_txen_in;
		end
		pe_rxd_out = (ctrl_in.loop_back && !io_test) ? pe_txd_in : rx_voted;
	end

	// protocol held off during clear and in any test mux mode
	assign protocol_enable_out = !s_q.clearing
		&& ctrl_in.test_mux_control == frtr_pkg::TMC_NORMAL;
	assign ram_clear_active_out = s_q.clearing;
	assign bus_activity_observed_out = s_q.active;
	assign coding_error_report_out = s_q.cer;
	assign int_flags_out = s_q.iflag;
	assign int_request_out = s_q.ireq;
	assign ram_rdata_out = s_q.rdata;
	assign ram_ecc_err_out = s_q.ecc;

	chk_clear_len: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		$rose(s_q.clearing) |-> s_q.clearing [*8])
		else $error("ram clear ended too early");
	chk_clear_end: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		$fell(s_q.clearing) |-> $past(s_q.init_cnt) == 12'(INIT_CYCLES - 1))
		else $error("clear flag fell at wrong count");
	chk_set_wins: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		int_event_in[0] |=> int_flags_out[0])
		else $error("interrupt set lost to clear");
	chk_req_edge: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		int_request_out[0] |-> !$past(int_flags_out[0]))
		else $error("request without rising flag");
	chk_fes_first: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		rx_err_in.frame_end && rx_err_in.fes_err
		|=> coding_error_report_out == frtr_pkg::CER_FES)
		else $error("crc reported over decoding error");
	chk_no_proto: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		ram_clear_active_out |-> !protocol_enable_out)
		else $error("protocol enabled during clear");
	chk_ecc_unwr: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		ram_rd_in && !s_q.clearing && !written_q[ram_addr_in]
		|=> ram_ecc_err_out)
		else $error("unwritten read without ecc error");
	chk_act_low: assert property (
		@(posedge sys_clk_in) disable iff (reset_in)
		sample_en && !rx_voted |=> bus_activity_observed_out)
		else $error("activity not seen on low sample");
endmodule : frtr_core
`default_nettype wire

// ===== frtr_xcvr_model.sv
// transceiver model that echoes the transmit pin back to the receive pin
`timescale 1ns/1ns
`default_nettype none
module frtr_xcvr_model #(
	parameter int DELAY = 2
) (
	// clock
	input wire logic sys_clk_in,
	// pins
	input wire logic transmit_data_line_in,
	input wire logic transmit_enable_line_in,
	output logic rx_line_out
);
	logic [DELAY-1:0] dly_q = '1;
	// two-clock loop delay seen by the receiver
	// a disabled transmitter leaves the bus idle, which reads high
	always @(posedge sys_clk_in) begin
		dly_q <= {dly_q[DELAY-2:0],
			transmit_data_line_in | transmit_enable_line_in};
	end
	assign rx_line_out = dly_q[DELAY-1];
endmodule : frtr_xcvr_model
`default_nettype wire

// ===== frtr_core_tb_top.sv
// self-checking bench for the test and ram-init block
`timescale 1ns/1ns
`default_nettype none
module frtr_core_tb_top;
	localparam int INIT = 20;
	logic clk = 0, rst = 1, wr = 0, rd = 0, rxl, ptx = 1, pen = 0;
	logic [3:0] adr = '0;
	logic [31:0] wd = '0, rdat;
	logic [1:0] clr = '0, ev = '0, cer, flg, req;
	frtr_pkg::frtr_ctrl_t c = '0;
	frtr_pkg::frtr_rx_err_t rxe = '0;
	logic ecc, prxd, pe, txd, txen, cact, act;
	int bad_count = 0, n_checks = 0, cyc = 0, n;
	always #2 clk = ~clk;
	frtr_core #(.RAM_WORDS(16), .ADDR_W(4), .INIT_CYCLES(INIT)) DUT (
		.sys_clk_in(clk), .reset_in(rst), .ctrl_in(c), .int_clear_in(clr),
		.ram_wr_in(wr), .ram_rd_in(rd), .ram_addr_in(adr),
		.ram_wdata_in(wd), .ram_rdata_out(rdat), .ram_ecc_err_out(ecc),
		.int_event_in(ev), .rx_err_in(rxe), .pe_txd_in(ptx),
		.pe_txen_in(pen), .rx_line_in(rxl), .pe_rxd_out(prxd),
		.protocol_enable_out(pe), .transmit_data_line_out(txd),
		.transmit_enable_line_out(txen), .ram_clear_active_out(cact),
		.bus_activity_observed_out(act), .coding_error_report_out(cer),
		.int_flags_out(flg), .int_request_out(req));
	frtr_xcvr_model XCVR (.sys_clk_in(clk), .transmit_data_line_in(txd),
		.transmit_enable_line_in(txen), .rx_line_out(rxl));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask : chk
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic wait_clear;
		n = 0;
		while (cact === 1'b1 && n < 100) begin
			chk(pe, 0, "protocol enabled while clearing");
			step();
			n++;
		end
	endtask : wait_clear
	task automatic wait_act(input logic v);
		n = 0;
		while (act !== v && n < 400) begin
			step();
			n++;
		end
		chk(act, v, "bus activity");
	endtask : wait_act
	task automatic clear_cmd;
		@(posedge clk) begin
			c.cmd <= frtr_pkg::CMD_RAM_CLEAR_COMMAND;
			c.cmd_strobe <= 1;
			c.test_mux_control <= frtr_pkg::TMC_RAM_TEST;
		end
		@(posedge clk) c.cmd_strobe <= 0;
		#1 chk(cact, 1, "clear not started");
		wait_clear();
		chk(n, INIT, "clear length");
		chk(pe, 0, "protocol on in ram test");
		@(posedge clk) c.test_mux_control <= frtr_pkg::TMC_NORMAL;
		#1 chk(pe, 1, "protocol not enabled");
	endtask : clear_cmd
	task automatic ram_rw(input logic w, input logic [3:0] a,
		input logic [31:0] d, e);
		if (w) begin
			@(posedge clk) begin wr <= 1; adr <= a; wd <= d; end
			@(posedge clk) wr <= 0;
		end
		@(posedge clk) begin rd <= 1; adr <= a; end
		@(posedge clk) rd <= 0;
		#1 chk(rdat, e, "read data");
		chk(ecc, 0, "ecc flag");
	endtask : ram_rw
	task automatic irq_race(input int i);
		@(posedge clk) ev[i] <= 1;
		@(posedge clk) begin ev[i] <= 1; clr[i] <= 1; end
		#1 chk(req[i], 1, "first request");
		@(posedge clk) begin ev[i] <= 0; clr[i] <= 0; end
		#1 chk(flg[i], 1, "race lost flag");
		chk(req[i], 0, "request without rise");
		@(posedge clk) clr[i] <= 1;
		@(posedge clk) begin clr[i] <= 0; ev[i] <= 1; end
		#1 chk(flg[i], 0, "flag not cleared");
		@(posedge clk) ev[i] <= 0;
		#1 chk(req[i], 1, "request after clear");
	endtask : irq_race
	task automatic cer_case(input logic cr, fe, ot, input logic [1:0] e);
		@(posedge clk) rxe <= '{cr, fe, ot, 1'b1};
		@(posedge clk) rxe <= '0;
		#1 chk(cer, e, "coding error report");
	endtask : cer_case
	task automatic io_loop;
		wait_act(0);
		@(posedge clk) begin
			c.test_mux_control <= frtr_pkg::TMC_IO_TEST;
			c.io_txd <= 0;
			c.io_txen <= 0;
		end
		#1 chk({txd, txen, pe}, 0, "io test pins");
		wait_act(1);
		@(posedge clk) c.test_mux_control <= frtr_pkg::TMC_NORMAL;
		wait_act(0);
	endtask : io_loop
	task automatic loop_tx;
		@(posedge clk) begin
			c.loop_back <= 1;
			c.async_tx_mode <= 1;
		end
		repeat (2) begin
			@(posedge clk) ptx <= 0;
			#1 chk(prxd, 0, "loop-back low");
			@(posedge clk) ptx <= 1;
			#1 chk(prxd, 1, "loop-back high");
			wait_act(0);
		end
		@(posedge clk) begin
			c.loop_back <= 0;
			c.async_tx_mode <= 0;
			ptx <= 0;
		end
		#1 chk(prxd, 1, "voted receive path");
		@(posedge clk) ptx <= 1;
	endtask : loop_tx
	task automatic reset_exit;
		@(posedge clk) begin
			c.test_mux_control <= frtr_pkg::TMC_IO_TEST;
			c.loop_back <= 1;
			rst <= 1;
		end
		repeat (2) @(posedge clk);
		#1 chk({cact, flg, req, cer, act}, 8'h80, "state in reset");
		@(posedge clk) begin
			rst <= 0;
			c <= '0;
		end
		#1 wait_clear();
		chk(n, INIT, "clear after reset");
		chk(pe, 1, "protocol after reset");
	endtask : reset_exit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 chk(cact, 1, "clear during reset");
		@(posedge clk) rst <= 0;
		#1 wait_clear();
		chk(n, INIT, "reset clear length");
		ram_rw(0, 4'h5, '0, frtr_pkg::RAM_CLEAR_VALUE);
		ram_rw(1, 4'h3, 32'hA5C3_0F01, 32'hA5C3_0F01);
		clear_cmd();
		ram_rw(0, 4'h3, '0, frtr_pkg::RAM_CLEAR_VALUE);
		irq_race(0);
		irq_race(1);
		cer_case(1, 1, 0, frtr_pkg::CER_FES);
		cer_case(1, 0, 0, frtr_pkg::CER_CRC);
		cer_case(0, 0, 1, frtr_pkg::CER_OTHER);
		cer_case(0, 0, 0, frtr_pkg::CER_NONE);
		io_loop();
		loop_tx();
		reset_exit();
		complete_run();
	end
endmodule : frtr_core_tb_top
`default_nettype wire
